// >>> rtl/ebt_pkg.sv
// Behaviour
// R1: Eight-bit counter increments on each selected clock event while tick_enable is set.
// R2: Software write loads a new starting count; reads return the live count.
// R3: Source zero uses instruction clock; source one with low clock zero uses pin.
// R4: Source and low clock both set count the slow oscillator chosen by configuration.
// R5: Pin or slow oscillator count on falling edges when edge select is one.
// R6: Software should enable prescaler above four when counting the slow oscillator.
// R7: Selected clock passes through the prescaler only while prescaler_assign is zero.
// R8: Writing zero to prescaler_assign assigns and clears the prescaler after the write.
// R9: Three-bit prescaler_ratio selects division from two up to two hundred fifty-six.
// R10: Counter overflow sets overflow_flag, bit zero of the interrupt flag register.
// R11: Interrupt request raised when flag, overflow enable and global enable are all set.
// R12: Flag stays set until software writes zero to it.
// R13: Ratio codes zero to seven give divide by 2, 4, 8 up to 256.
// R14: Counter wraps from maximum to zero and keeps counting.
package ebt_pkg;
    localparam int CNT_W = 8;
    localparam int PS_W = 8;
    localparam int RATIO_W = 3;
    localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;
    localparam logic [PS_W-1:0] PS_RST = 8'h00;
    localparam logic [RATIO_W-1:0] RATIO_RST = 3'h0;

    typedef struct packed {
        logic tick_enable;
        logic tick_source_sel;
        logic low_clock_sel;
        logic tick_edge_sel;
        logic prescaler_assign;
        logic [RATIO_W-1:0] prescaler_ratio;
        logic crystal_sel;
    } ebt_cfg_t;

    typedef enum logic [2:0] {
        SRC_INSTR = 3'h1,
        SRC_PIN = 3'h2,
        SRC_SLOW = 3'h4
    } ebt_src_t;
endpackage

// >>> rtl/ebt_prescaler.sv
`timescale 1ns/1ns
module ebt_prescaler #(
    parameter int PS_W = ebt_pkg::PS_W
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic clear_i,
    input wire logic tick_i,
    input wire logic [ebt_pkg::RATIO_W-1:0] ratio_i,
    output logic tick_o
);
    logic [PS_W-1:0] count;
    logic [PS_W-1:0] next_count;
    logic [PS_W-1:0] mask;
    wire wrap;

    // R13: ratio code maps to mask
    assign mask = PS_W'((9'h002 << ratio_i) - 9'h001);
    assign next_count = count + PS_W'(1);
    // R9: divide by two up to 256
    assign wrap = tick_i && ((count & mask) == mask);

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count <= ebt_pkg::PS_RST;
            tick_o <= 1'b0;
        end else if (clear_i) begin
            count <= ebt_pkg::PS_RST;
            tick_o <= 1'b0;
        end else begin
            tick_o <= wrap;
            if (tick_i) begin
                count <= next_count;
            end
        end
    end
endmodule

// >>> rtl/ebt_timer.sv
`timescale 1ns/1ns
module ebt_timer (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic instr_tick_i,
    input wire logic ext_count_clock_i,
    input wire logic internal_slow_osc_i,
    input wire logic crystal_slow_osc_i,
    input wire ebt_pkg::ebt_cfg_t cfg_i,
    input wire logic assign_wr_i,
    input wire logic count_wr_i,
    input wire logic [ebt_pkg::CNT_W-1:0] count_wdata_i,
    input wire logic flag_clr_i,
    input wire logic overflow_irq_enable_i,
    input wire logic global_irq_enable_i,
    output logic [ebt_pkg::CNT_W-1:0] count_o,
    output logic overflow_flag_o,
    output logic irq_o
);
    // ****************************************
    // Source selection and edge detection
    // ****************************************
    // Two edge detectors share one loop: bit 0 watches the pin, bit 1 the slow oscillator.
    localparam int EDGE_N = 2;
    localparam int EDGE_PIN = 0;
    localparam int EDGE_SLOW = 1;

    logic [EDGE_N-1:0] edge_lvl;
    logic [EDGE_N-1:0] edge_q;
    logic [EDGE_N-1:0] edge_hit;
    logic primed;
    logic ps_clear;
    logic ps_tick;
    logic src_tick_r;
    ebt_pkg::ebt_src_t src;
    logic [ebt_pkg::CNT_W-1:0] next_count;
    wire slow_lvl;
    wire pin_edge;
    wire slow_edge;
    wire src_tick;
    wire ps_in;
    wire cnt_tick;
    wire overflow;
    wire next_flag;
    wire next_irq;

    // R3: instruction clock or pin
    // R4: slow oscillator selection
    always_comb begin
        if (!cfg_i.tick_source_sel) begin
            src = ebt_pkg::SRC_INSTR;
        end else if (cfg_i.low_clock_sel) begin
            src = ebt_pkg::SRC_SLOW;
        end else begin
            src = ebt_pkg::SRC_PIN;
        end
    end

    // R4: configuration picks oscillator
    assign slow_lvl = cfg_i.crystal_sel ? crystal_slow_osc_i : internal_slow_osc_i;
    // Bit order follows EDGE_PIN and EDGE_SLOW.
    assign edge_lvl = {slow_lvl, ext_count_clock_i};

    // Both detectors run all the time, so switching the source never compares a stale level.
    // The price is that a level change in the cycle of a switch may count once on the new source.
    for (genvar g = 0; g < EDGE_N; g++) begin : g_edge
        // R5: edge polarity select
        assign edge_hit[g] = primed && (cfg_i.tick_edge_sel ? (edge_q[g] && !edge_lvl[g])
                                                            : (!edge_q[g] && edge_lvl[g]));
    end
    assign pin_edge = edge_hit[EDGE_PIN];
    assign slow_edge = edge_hit[EDGE_SLOW];

    always_comb begin
        case (src)
            ebt_pkg::SRC_INSTR: src_tick_r = instr_tick_i;
            ebt_pkg::SRC_PIN: src_tick_r = pin_edge;
            ebt_pkg::SRC_SLOW: src_tick_r = slow_edge;
            default: src_tick_r = 1'b0;
        endcase
    end
    assign src_tick = src_tick_r;

    // Edges are held back for one cycle after reset: the reset value of edge_q may
    // differ from the level at which the pin rests, which would count a false edge.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            edge_q <= {EDGE_N{1'b0}};
            primed <= 1'b0;
            ps_clear <= 1'b0;
        end else begin
            edge_q <= edge_lvl;
            primed <= 1'b1;
            // R8: clear once the write completes
            ps_clear <= assign_wr_i && !cfg_i.prescaler_assign;
        end
    end

    // ****************************************
    // Prescaler and counter
    // ****************************************
    // R7: only assigned sources feed the prescaler
    // The prescaler sees no events while it is not assigned, so it cannot drift meanwhile.
    assign ps_in = src_tick && !cfg_i.prescaler_assign;

    ebt_prescaler #(
        .PS_W(ebt_pkg::PS_W)
    ) u_ps (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .clear_i(ps_clear),
        .tick_i(ps_in),
        .ratio_i(cfg_i.prescaler_ratio),
        .tick_o(ps_tick)
    );

    // R7: prescaler in path when assigned
    assign cnt_tick = cfg_i.tick_enable && (cfg_i.prescaler_assign ? src_tick : ps_tick);
    // R14: wrap to zero
    assign overflow = cnt_tick && !count_wr_i && (count_o == ebt_pkg::CNT_MAX);
    // R2: software load wins
    // R1: count while enabled
    // A tick that meets a software load is dropped: adding it on top would turn a load
    // of the maximum into an overflow that software never asked for.
    assign next_count = count_wr_i ? count_wdata_i
                      : cnt_tick ? count_o + ebt_pkg::CNT_W'(1)
                      : count_o;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count_o <= ebt_pkg::CNT_RST;
        end else begin
            count_o <= next_count;
        end
    end

    // ****************************************
    // Overflow flag and interrupt request
    // ****************************************
    // R10: overflow sets flag
    // R12: held until cleared
    // A clear that meets a new overflow loses, so no overflow goes unreported.
    assign next_flag = overflow || (overflow_flag_o && !flag_clr_i);
    // R11: gated request
    // The request follows the enables of the cycle before, one cycle late.
    assign next_irq = next_flag && overflow_irq_enable_i && global_irq_enable_i;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            overflow_flag_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            overflow_flag_o <= next_flag;
            irq_o <= next_irq;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_wrap_sets_flag: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R10
        overflow |=> overflow_flag_o && count_o == ebt_pkg::CNT_RST)
        else $error("overflow did not set flag and wrap");
    a_flag_holds: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R12
        overflow_flag_o && !flag_clr_i |=> overflow_flag_o)
        else $error("flag dropped without clear");
    a_load_count: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R2
        count_wr_i |=> count_o == $past(count_wdata_i))
        else $error("write did not load count");
    a_disabled_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R1
        !cfg_i.tick_enable && !count_wr_i |=> $stable(count_o))
        else $error("count moved while disabled");
    a_instr_count: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R3
        cfg_i.tick_enable && !cfg_i.tick_source_sel && cfg_i.prescaler_assign
        && instr_tick_i && !count_wr_i |=> count_o == $past(count_o) + ebt_pkg::CNT_W'(1))
        else $error("instruction tick not counted");
    a_ps_clear: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R8
        ps_clear |=> !ps_tick)
        else $error("prescaler not cleared");
    a_irq_gate: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R11
        irq_o |-> $past(overflow_irq_enable_i) && $past(global_irq_enable_i))
        else $error("irq without enables");
    a_no_tick_bypass: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R7
        !cfg_i.prescaler_assign && !ps_tick && !count_wr_i |=> $stable(count_o))
        else $error("count bypassed prescaler");

    a_set_beats_clear: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R10
        overflow && flag_clr_i |=> overflow_flag_o)
        else $error("clear beat a new overflow");

    a_flag_clear: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R12
        flag_clr_i && !overflow |=> !overflow_flag_o)
        else $error("flag not cleared by write");

    a_irq_raise: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R11
        overflow_flag_o && !flag_clr_i && overflow_irq_enable_i && global_irq_enable_i
        |=> irq_o)
        else $error("irq missing with flag and enables");

    a_irq_drop: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R11
        !(overflow_irq_enable_i && global_irq_enable_i) |=> !irq_o)
        else $error("irq raised while masked");

    a_pin_rise_count: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R5
        cfg_i.tick_enable && cfg_i.prescaler_assign && cfg_i.tick_source_sel
        && !cfg_i.low_clock_sel && !cfg_i.tick_edge_sel && primed
        && !edge_q[EDGE_PIN] && ext_count_clock_i && !count_wr_i
        |=> count_o == $past(count_o) + ebt_pkg::CNT_W'(1))
        else $error("rising pin edge not counted");

    a_pin_fall_count: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R5
        cfg_i.tick_enable && cfg_i.prescaler_assign && cfg_i.tick_source_sel
        && !cfg_i.low_clock_sel && cfg_i.tick_edge_sel && primed
        && edge_q[EDGE_PIN] && !ext_count_clock_i && !count_wr_i
        |=> count_o == $past(count_o) + ebt_pkg::CNT_W'(1))
        else $error("falling pin edge not counted");

    a_slow_fall_count: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R4
        cfg_i.tick_enable && cfg_i.prescaler_assign && cfg_i.tick_source_sel
        && cfg_i.low_clock_sel && cfg_i.tick_edge_sel && primed
        && edge_q[EDGE_SLOW] && !slow_lvl && !count_wr_i
        |=> count_o == $past(count_o) + ebt_pkg::CNT_W'(1))
        else $error("slow oscillator edge not counted");

    a_prescaled_count: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i) // R7
        cfg_i.tick_enable && !cfg_i.prescaler_assign && ps_tick && !count_wr_i
        |=> count_o == $past(count_o) + ebt_pkg::CNT_W'(1))
        else $error("prescaler tick not counted");
endmodule

// >>> bench/ebt_timer_tb_top.sv
`timescale 1ns/1ns
module ebt_timer_tb_top;
    logic clk_sys_i = 1'h0;
    logic sys_rst_i = 1'h1;
    logic instr_tick = 1'h0;
    logic [2:0] pin = 3'h0;
    ebt_pkg::ebt_cfg_t cfg = '0;
    logic assign_wr = 1'h0;
    logic count_wr = 1'h0;
    logic [7:0] wdata = 8'h00;
    logic flag_clr = 1'h0;
    logic oie = 1'h0;
    logic global_irq_enable = 1'h0;
    logic [7:0] count;
    logic flag;
    logic irq;
    int err_total = 0;
    int compares = 0;
    int exp_cnt;
    int n;
    logic [15:0] seed = 16'h881F;

    ebt_timer u_ebt_timer (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .instr_tick_i(instr_tick), .ext_count_clock_i(pin[0]), .internal_slow_osc_i(pin[1]),
        .crystal_slow_osc_i(pin[2]), .cfg_i(cfg), .assign_wr_i(assign_wr),
        .count_wr_i(count_wr), .count_wdata_i(wdata), .flag_clr_i(flag_clr),
        .overflow_irq_enable_i(oie), .global_irq_enable_i(global_irq_enable), .count_o(count),
        .overflow_flag_o(flag), .irq_o(irq));

    // ****************
    // Bench helpers
    // ****************
    initial begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic cyc(input int k);
        repeat (k) @(negedge clk_sys_i);
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        compares++;
        if (seen !== want) begin
            err_total++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask

    task automatic ticks(input int k);
        repeat (k) begin
            instr_tick = 1'h1;
            cyc(1);
            instr_tick = 1'h0;
            cyc(1);
        end
    endtask

    // The flag is cleared with every load so each scenario starts clean.
    task automatic wr(input logic [7:0] v);
        count_wr = 1'h1;
        wdata = v;
        flag_clr = 1'h1;
        cyc(1);
        count_wr = 1'h0;
        flag_clr = 1'h0;
        cyc(1);
    endtask

    // The spare cycle lets the prescaler clear land before the next tick.
    task automatic clr_ps;
        assign_wr = 1'h1;
        cyc(1);
        assign_wr = 1'h0;
        cyc(2);
    endtask

    task automatic give_verdict;
        if (err_total == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk_sys_i);
        err_total++;
        give_verdict();
    end

    // ****************
    // Scenarios
    // ****************
    initial begin
        cfg.prescaler_assign = 1'h1;
        cyc(16);
        sys_rst_i = 1'h0;
        cyc(1);
        chk(count, 8'h00); // reset count
        cfg.tick_enable = 1'h1;
        wr(8'hFF);
        ticks(1);
        cyc(2);
        chk(count, 8'h00); // wrap to zero
        for (int i = 0; i < 4; i++) begin
            {oie, global_irq_enable} = 2'(i);
            cyc(2);
            chk({7'h00, flag}, 8'h01); // flag holds
            chk({7'h00, irq}, {7'h00, i == 3}); // irq gating
        end
        flag_clr = 1'h1;
        cyc(1);
        flag_clr = 1'h0;
        cyc(2);
        chk({6'h00, flag, irq}, 8'h00); // flag cleared
        // A clear in the cycle of a new overflow must lose.
        wr(8'hFF);
        flag_clr = 1'h1;
        instr_tick = 1'h1;
        cyc(1);
        flag_clr = 1'h0;
        instr_tick = 1'h0;
        cyc(2);
        chk({6'h00, flag, irq}, 8'h03); // set beats clear
        repeat (8) begin
            seed = lfsr(seed);
            cfg.tick_enable = seed[13];
            wr(seed[7:0]);
            n = int'(seed[12:8]);
            ticks(n);
            cyc(2);
            exp_cnt = seed[13] ? int'(seed[7:0]) + n : int'(seed[7:0]);
            chk(count, exp_cnt[7:0]); // loaded count, plus the ticks when enabled
            chk({7'h00, flag}, {7'h00, exp_cnt > 255}); // overflow flag
        end
        cfg.tick_enable = 1'h1;
        for (int s = 0; s < 6; s++) begin
            cfg.tick_source_sel = 1'h1;
            cfg.low_clock_sel = s > 1;
            cfg.crystal_sel = s > 3;
            cfg.tick_edge_sel = s[0];
            wr(8'h10);
            exp_cnt = 16;
            repeat (4) begin
                pin[s/2] ^= 1'h1;
                ticks(1);
                cyc(2);
                if (pin[s/2] == ~cfg.tick_edge_sel) exp_cnt++;
                chk(count, exp_cnt[7:0]); // source and edge
            end
        end
        cfg.tick_source_sel = 1'h0;
        cfg.low_clock_sel = 1'h0;
        cfg.prescaler_assign = 1'h0;
        for (int r = 0; r < 8; r++) begin
            cfg.prescaler_ratio = 3'(r);
            wr(8'h00);
            clr_ps();
            ticks((2 << r) - 1);
            clr_ps();
            ticks((2 << r) - 1);
            cyc(2);
            chk(count, 8'h00); // prescaler cleared
            ticks(1);
            cyc(3);
            chk(count, 8'h01); // division ratio
        end
        // slow source behind a prescaler above four
        cfg.tick_source_sel = 1'h1;
        cfg.low_clock_sel = 1'h1;
        cfg.crystal_sel = 1'h0;
        cfg.tick_edge_sel = 1'h0;
        cfg.prescaler_ratio = 3'h2;
        wr(8'h00);
        clr_ps();
        for (int t = 1; t <= 16; t++) begin
            pin[1] ^= 1'h1;
            cyc(3);
            if (t == 14 || t == 16) chk(count, {7'h00, t == 16}); // eight slow edges
        end
        give_verdict();
    end
endmodule
